// ===== hdl/adc_conversion_sequencer.sv
// successive-approximation converter sequencer: timing, scan, formatting and compare
`timescale 1ns/1ps
`include "adc_seq_defs.svh"

// Functional notes
// [R1] sampling lengthens in half converter cycles, up to 64 cycles
// [R2] reference selector offers bandgap 1.00V, supply/1.6, supply/2, two external pins
// [R3] result goes to the result register; one sign setting for all
// [R4] software picks signed mode whenever differential inputs are used
// [R5] signed 12-bit results span -2048 to +2047, 0xf800 to 0x07ff
// [R6] unsigned results span 0 to 4095, up to 0x0fff
// [R7] gain is one half to 64 for differential, fixed one otherwise
// [R8] 8-bit and 12-bit precision; 8-bit finishes in fewer cycles
// [R9] 16-bit result, right aligned by default; 12-bit may be left aligned
// [R10] signed results are sign extended from bit 11 or bit 7
// [R11] 12-bit threshold compare flags results above or below it
// [R12] a conversion starts on a start write or any routed event
// [R13] software sets the input selection before triggering a conversion
// [R14] scan converts first input, then increments after each conversion up to count
// [R15] converter clock is the peripheral clock through a programmable prescaler
// [R16] latency is 1 + (resolution+1+gain stages)/2 converter cycles
// [R17] a new conversion may follow the previous one with no gap
// [R18] msb first, remaining bits over three and a half or five and a half cycles, half cycle each
// [R19] final cycle assembles result, then sets completion flag and result
// [R20] start must be seen one peripheral cycle before the starting edge
// [R21] input is sampled in the first half of the first cycle
// [R22] each gain doubling adds a half-cycle pipeline stage
// [R23] start bit clears by hardware once the conversion has begun
// [R24] precision 00 12 right, 10 8 right, 11 12 left, 01 reserved
// [R25] sign mode resets to unsigned; setting it selects signed
// [R26] continuous mode converts the next input as each conversion finishes
// [R27] after a full scan the selection returns to the first input
// [R28] sample extension value counts added half cycles; zero is one half
module adc_conversion_sequencer
	import adc_seq_pkg::*;
(
	input  wire logic         core_clk_i,
	input  wire logic         rst_b_i,
	input  wire logic         enable_i,
	input  wire logic [2:0]   prescale_i,
	input  wire logic         start_write_i,
	input  wire logic         event_i,
	input  wire logic         sign_mode_select_i,
	input  wire logic         continuous_conversion_i,
	input  wire logic [1:0]   precision_i,
	input  wire logic [2:0]   reference_select_i,
	input  wire logic [1:0]   input_mode_i,
	input  wire logic [2:0]   gain_select_i,
	input  wire logic [3:0]   input_selector_i,
	input  wire logic [3:0]   scan_count_i,
	input  wire logic [6:0]   sample_extension_value_i,
	input  wire logic [11:0]  threshold_i,
	input  wire logic         compare_enable_i,
	input  wire logic         compare_above_i,
	input  wire logic         clear_complete_i,
	input  wire logic         clear_compare_i,
	input  wire logic         comparator_i,
	output logic              converter_clock_o,
	output logic              sample_o,
	output logic [11:0]       sar_trial_o,
	output logic [3:0]        positive_input_o,
	output logic [2:0]        gain_code_o,
	output logic [2:0]        reference_o,
	output logic              channel_start_bit_o,
	output logic              busy_o,
	output logic [15:0]       result_o,
	output logic              complete_flag_o,
	output logic              compare_flag_o
);

	conv_state_t  state_reg;
	conv_state_t  state_next;
	logic [9:0]   presc_cnt_reg;
	logic         clk_reg;
	logic         pending_reg;
	logic         comp_meta_reg;
	logic         comp_sync_reg;
	logic [6:0]   cnt_reg;
	logic [6:0]   cnt_next;
	logic [3:0]   bit_idx_reg;
	logic [3:0]   bit_idx_next;
	raw_code_t    sar_reg;
	raw_code_t    sar_next;
	logic [3:0]   scan_idx_reg;
	logic [3:0]   scan_idx_next;
	logic [1:0]   prec_reg;
	logic         signed_reg;
	logic [2:0]   stages_reg;
	logic [2:0]   gain_reg;
	result_word_t result_reg;
	logic         complete_reg;
	logic         compare_reg;

	wire logic [9:0] half_len     = `HALF_BASE_CYCLES << prescale_i;
	// a compare on >= keeps a prescale lowered mid-half from wrapping the counter
	wire logic       half_tick    = enable_i && (presc_cnt_reg >= half_len - 10'h001);
	wire logic       rise_tick    = half_tick && !clk_reg;
	wire logic       is_gain_mode = (input_mode_i == `MODE_DIFF_GAIN);
	wire logic [2:0] gain_eff     = is_gain_mode ? gain_select_i : `GAIN_UNITY;
	wire logic [2:0] stages_eff   = (gain_eff == `GAIN_HALF) ? `GAIN_HALF_STAGES : gain_eff;
	wire logic       begin_idle   = (state_reg == idle_s) && rise_tick && pending_reg;
	wire logic       last_tick    = (state_reg == final_s) && half_tick && (cnt_reg == 7'h00);
	wire logic       scan_done    = (scan_idx_reg == scan_count_i);
	// [R17] [R26] chain with no gap
	wire logic       chain        = last_tick && enable_i
	                                && (!scan_done || continuous_conversion_i || pending_reg);
	wire logic       begin_conv   = begin_idle || chain;
	wire logic [3:0] low_bit      = (prec_reg == `PREC_8_RIGHT) ? `RAW_LSB_8BIT : `RAW_LSB_12BIT;
	wire raw_code_t  done_code    = sar_reg;
	wire result_word_t formatted  = format_result(done_code, prec_reg, signed_reg);
	wire logic       hit          = compare_hit(formatted, prec_reg, signed_reg,
	                                            threshold_i, compare_above_i);

	// result in two's complement when signed; offset binary code from the array
	function automatic result_word_t format_result(input raw_code_t raw,
	                                               input logic [1:0] prec,
	                                               input logic sgn);
		raw_code_t    v;
		result_word_t w;
		// [R5] offset to two's complement
		v = sgn ? (raw ^ `RAW_MID_CODE) : raw;
		// [R9] alignment choice
		case (prec)
			`PREC_8_RIGHT:
			begin
				// [R10] sign fills high byte
				w = {{8{sgn & v[`RAW_MSB]}}, v[11:4]};
			end
			`PREC_12_LEFT:
			begin
				w = {v, 4'h0};
			end
			default:
			begin
				// [R10] bit 11 padded upward
				w = {{4{sgn & v[`RAW_MSB]}}, v};
			end
		endcase
		return w;
	endfunction

	// the 8-bit value is widened to 13 bits before comparing with the threshold
	function automatic logic compare_hit(input result_word_t w, input logic [1:0] prec,
	                                     input logic sgn, input logic [11:0] th,
	                                     input logic above);
		logic [12:0] a;
		logic [12:0] b;
		logic        gt;
		logic        lt;
		if (prec == `PREC_12_LEFT)
			a = {sgn & w[15], w[15:4]};
		else if (prec == `PREC_8_RIGHT)
			a = {{5{sgn & w[7]}}, w[7:0]};
		else
			a = {sgn & w[11], w[11:0]};
		b = {sgn & th[11], th};
		gt = $signed(a) > $signed(b);
		lt = $signed(a) < $signed(b);
		// [R11] above or below threshold
		return above ? gt : lt;
	endfunction

	always_comb
	begin
		state_next    = state_reg;
		cnt_next      = cnt_reg;
		bit_idx_next  = bit_idx_reg;
		sar_next      = sar_reg;
		scan_idx_next = scan_idx_reg;
		if (!enable_i)
		begin
			state_next    = idle_s;
			// an abort also drops a scan in flight
			scan_idx_next = `INPUT_RESET;
		end
		else if (begin_conv)
		begin
			// [R28] extension in half cycles
			state_next = sample_s;
			cnt_next   = sample_extension_value_i;
			sar_next   = `SAR_RESET;
			if (begin_idle)
				// [R27] scan restarts at first input
				scan_idx_next = `INPUT_RESET;
		end
		else if (half_tick)
		begin
			case (state_reg)
				sample_s:
				begin
					// [R1] hold sampling for the extension
					if (cnt_reg != 7'h00)
						cnt_next = cnt_reg - 7'h01;
					else if (stages_reg != 3'h0)
					begin
						// [R22] one half cycle per stage
						state_next = gain_s;
						cnt_next   = {4'h0, stages_reg} - 7'h01;
					end
					else
					begin
						state_next   = bits_s;
						bit_idx_next = `RAW_MSB;
						sar_next     = `RAW_MID_CODE;
					end
				end
				gain_s:
				begin
					if (cnt_reg != 7'h00)
						cnt_next = cnt_reg - 7'h01;
					else
					begin
						state_next   = bits_s;
						bit_idx_next = `RAW_MSB;
						sar_next     = `RAW_MID_CODE;
					end
				end
				bits_s:
				begin
					// [R18] one bit per half cycle, msb first
					sar_next[bit_idx_reg] = comp_sync_reg;
					if (bit_idx_reg == low_bit)
					begin
						// [R8] 8-bit stops four bits early
						state_next = final_s;
						cnt_next   = `FINAL_HALVES_M1;
					end
					else
					begin
						bit_idx_next           = bit_idx_reg - 4'h1;
						sar_next[bit_idx_next] = 1'b1;
					end
				end
				// [R16] two closing halves end the latency
				final_s:
				begin
					if (cnt_reg != 7'h00)
						cnt_next = cnt_reg - 7'h01;
					else
						state_next = idle_s;
				end
				default:
				begin
					state_next = idle_s;
				end
			endcase
		end
		if (last_tick)
		begin
			// [R14] advance the positive input
			scan_idx_next = scan_done ? `INPUT_RESET : scan_idx_reg + 4'h1;
		end
	end

	// [R15] prescaled half-cycle ticks
	always_ff @(posedge core_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			presc_cnt_reg <= 10'h000;
			clk_reg       <= 1'b0;
		end
		else if (!enable_i || half_tick)
		begin
			presc_cnt_reg <= 10'h000;
			clk_reg       <= enable_i && !clk_reg;
		end
		else
			presc_cnt_reg <= presc_cnt_reg + 10'h001;
	end

	// comparator level crosses from the analog side
	always_ff @(posedge core_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			comp_meta_reg <= 1'b0;
			comp_sync_reg <= 1'b0;
		end
		else
		begin
			comp_meta_reg <= comparator_i;
			comp_sync_reg <= comp_meta_reg;
		end
	end

	// [R12] start write or event; [R20] registered, so seen a cycle ahead
	always_ff @(posedge core_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			pending_reg <= 1'b0;
		else
			// [R23] cleared at begin, a new request wins
			pending_reg <= (pending_reg && !begin_conv) || start_write_i || event_i;
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			state_reg    <= idle_s;
			cnt_reg      <= 7'h00;
			bit_idx_reg  <= `RAW_MSB;
			sar_reg      <= `SAR_RESET;
			scan_idx_reg <= `INPUT_RESET;
		end
		else
		begin
			state_reg    <= state_next;
			cnt_reg      <= cnt_next;
			bit_idx_reg  <= bit_idx_next;
			sar_reg      <= sar_next;
			scan_idx_reg <= scan_idx_next;
		end
	end

	// settings are frozen per conversion so a mid-flight change cannot mix formats
	always_ff @(posedge core_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			prec_reg   <= `PREC_12_RIGHT;
			// [R25] unsigned after reset
			signed_reg <= 1'b0;
			stages_reg <= 3'h0;
			gain_reg   <= `GAIN_UNITY;
		end
		else if (begin_conv)
		begin
			// [R24] reserved code acts as 12 right
			prec_reg   <= (precision_i == `PREC_RESERVED) ? `PREC_12_RIGHT : precision_i;
			// [R3] one sign setting for the converter
			signed_reg <= sign_mode_select_i;
			// [R7] gain only with differential gain mode
			stages_reg <= stages_eff;
			gain_reg   <= gain_eff;
		end
	end

	// [R19] result and flags land together after the final cycle
	always_ff @(posedge core_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			result_reg   <= `RESULT_RESET;
			complete_reg <= 1'b0;
			compare_reg  <= 1'b0;
		end
		else
		begin
			if (last_tick)
				// [R6] unsigned code is the raw value
				result_reg <= formatted;
			complete_reg <= last_tick || (complete_reg && !clear_complete_i);
			// [R11] flag only when enabled and hit
			compare_reg  <= (last_tick && compare_enable_i && hit)
			                || (compare_reg && !clear_compare_i);
		end
	end

	// output flops
	always_ff @(posedge core_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			converter_clock_o   <= 1'b0;
			sample_o            <= 1'b0;
			sar_trial_o         <= `SAR_RESET;
			positive_input_o    <= `INPUT_RESET;
			gain_code_o         <= `GAIN_UNITY;
			reference_o         <= `REF_BANDGAP_1V;
			channel_start_bit_o <= 1'b0;
			busy_o              <= 1'b0;
			result_o            <= `RESULT_RESET;
			complete_flag_o     <= 1'b0;
			compare_flag_o      <= 1'b0;
		end
		else
		begin
			converter_clock_o   <= clk_reg;
			// [R21] sampling from the first half cycle
			sample_o            <= (state_reg == sample_s);
			sar_trial_o         <= sar_reg;
			positive_input_o    <= input_selector_i + scan_idx_reg;
			gain_code_o         <= gain_reg;
			// [R2] five references, others fall back to bandgap
			reference_o         <= (reference_select_i > `REF_LAST) ? `REF_BANDGAP_1V
			                                                       : reference_select_i;
			channel_start_bit_o <= pending_reg;
			busy_o              <= (state_reg != idle_s);
			result_o            <= result_reg;
			complete_flag_o     <= complete_reg;
			compare_flag_o      <= compare_reg;
		end
	end

endmodule

// ===== hdl/adc_seq_defs.svh
// constants for the conversion sequencer: codes, field positions, reset values, timing
`ifndef ADC_SEQ_DEFS_SVH
`define ADC_SEQ_DEFS_SVH

// precision field codes
`define PREC_12_RIGHT      2'b00
`define PREC_RESERVED      2'b01
`define PREC_8_RIGHT       2'b10
`define PREC_12_LEFT       2'b11

// input mode codes
`define MODE_DIFF          2'b00
`define MODE_DIFF_GAIN     2'b01
`define MODE_SINGLE        2'b10
`define MODE_INTERNAL      2'b11

// gain codes: 0 is 1x, n is 2^n x up to 64x, 7 is one half
`define GAIN_UNITY         3'h0
`define GAIN_HALF          3'h7
`define GAIN_HALF_STAGES   3'h1

// reference codes, five legal choices
`define REF_BANDGAP_1V     3'h0
`define REF_VCC_DIV_1P6    3'h1
`define REF_VCC_DIV_2      3'h2
`define REF_EXT_PIN_A      3'h3
`define REF_EXT_PIN_B      3'h4
`define REF_LAST           3'h4

// field positions and sizes
`define RAW_MSB            4'hb
`define RAW_LSB_8BIT       4'h4
`define RAW_LSB_12BIT      4'h0
`define RAW_MID_CODE       12'h800
`define SIGN_BIT_12        11
`define SIGN_BIT_8         7

// timing: converter clock is peripheral clock / (8 << prescale)
`define HALF_BASE_CYCLES   10'h004
`define FINAL_HALVES_M1    7'h01

// reset values
`define RESULT_RESET       16'h0000
`define SAR_RESET          12'h000
`define INPUT_RESET        4'h0

`endif

// ===== hdl/adc_seq_pkg.sv
// types shared by the conversion sequencer
package adc_seq_pkg;

	typedef enum logic [2:0] {
		idle_s,
		sample_s,
		gain_s,
		bits_s,
		final_s
	} conv_state_t;

	typedef logic [11:0] raw_code_t;
	typedef logic [15:0] result_word_t;

endpackage

// ===== test/adc_seq_chk.sv
// port-level assertions for the conversion sequencer
`timescale 1ns/1ps
module adc_seq_chk (
	input  wire logic        core_clk_i,
	input  wire logic        rst_b_i,
	input  wire logic        enable_i,
	input  wire logic        sign_mode_select_i,
	input  wire logic [1:0]  precision_i,
	input  wire logic [2:0]  reference_select_i,
	input  wire logic [3:0]  input_selector_i,
	input  wire logic        compare_enable_i,
	input  wire logic        sample_o,
	input  wire logic [3:0]  positive_input_o,
	input  wire logic [2:0]  reference_o,
	input  wire logic        channel_start_bit_o,
	input  wire logic        busy_o,
	input  wire logic [15:0] result_o,
	input  wire logic        complete_flag_o,
	input  wire logic        compare_flag_o
);
	default clocking
		@(posedge core_clk_i);
	endclocking
	default disable iff (!rst_b_i);

	a_start_clears: assert property ($fell(channel_start_bit_o) && $past(enable_i) |-> busy_o)
		else $error("start bit dropped with no conversion");
	a_begin_pending: assert property ($rose(busy_o) |-> $past(channel_start_bit_o) || $past(channel_start_bit_o, 2))
		else $error("conversion began without a start");
	a_sample_early: assert property ($rose(busy_o) |-> ##[0:2] sample_o)
		else $error("no sample phase at conversion begin");
	a_ref_fallback: assert property ($past(reference_select_i) > 3'h4 && $past(reference_select_i, 2) > 3'h4 |-> reference_o == 3'h0)
		else $error("illegal reference code passed on");
	a_sext_twelve: assert property ($rose(complete_flag_o) && sign_mode_select_i && precision_i == 2'b00 |-> result_o[15:12] == {4{result_o[11]}})
		else $error("12-bit result not sign extended");
	a_sext_eight: assert property ($rose(complete_flag_o) && sign_mode_select_i && precision_i == 2'b10 |-> result_o[15:8] == {8{result_o[7]}})
		else $error("8-bit result not sign extended");
	a_zero_fill: assert property ($rose(complete_flag_o) && !sign_mode_select_i && precision_i != 2'b11 |-> result_o[15:12] == 4'h0 && (precision_i != 2'b10 || result_o[15:8] == 8'h00))
		else $error("unsigned result not zero filled");
	a_left_align: assert property ($rose(complete_flag_o) && precision_i == 2'b11 |-> result_o[3:0] == 4'h0)
		else $error("left aligned result has low bits set");
	a_result_hold: assert property (!$stable(result_o) |-> $past(busy_o) || $past(busy_o, 2))
		else $error("result changed outside a conversion");
	a_cmp_complete: assert property ($rose(compare_flag_o) |-> complete_flag_o && $past(compare_enable_i))
		else $error("compare flag without enabled completion");
	a_scan_return: assert property (!busy_o && !$past(busy_o) && !$past(busy_o, 2) && $past(rst_b_i, 3) && $stable(input_selector_i) |-> positive_input_o == input_selector_i)
		else $error("idle input selection not back at first input");
endmodule

bind adc_conversion_sequencer adc_seq_chk chk (.*);

// ===== test/analog_source_model.sv
// comparator model standing for the analog input and reference chain
`timescale 1ns/1ps
module analog_source_model #(
	parameter int SETTLE_NS = 5
) (
	input  wire logic [11:0] level_i,
	input  wire logic [11:0] trial_i,
	output logic             comparator_o
);
	// settling delay lands mid-cycle; the design's synchroniser must absorb it
	assign #SETTLE_NS comparator_o = (level_i >= trial_i);
endmodule

// ===== test/tb_top.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`include "adc_seq_defs.svh"
module tb_top;
	logic        core_clk_i, rst_b_i, enable_i, start_write_i, event_i;
	logic        sign_mode_select_i, continuous_conversion_i, compare_enable_i;
	logic        compare_above_i, clear_complete_i, clear_compare_i, comparator_i;
	logic [2:0]  prescale_i, reference_select_i, gain_select_i, gain_code_o, reference_o;
	logic [1:0]  precision_i, input_mode_i;
	logic [3:0]  input_selector_i, scan_count_i, positive_input_o;
	logic [6:0]  sample_extension_value_i;
	logic [11:0] threshold_i, sar_trial_o, level;
	logic        converter_clock_o, sample_o, channel_start_bit_o, busy_o;
	logic        complete_flag_o, compare_flag_o;
	logic [15:0] result_o;
	int          miscompares, num_checks;
	int          rise_at[$];
	logic [3:0]  rise_in[$];

	adc_conversion_sequencer dut (.*);
	analog_source_model src (.level_i(level), .trial_i(sar_trial_o), .comparator_o(comparator_i));

	initial
	begin
		core_clk_i = 0;
		forever #12.5 core_clk_i = ~core_clk_i;
	end

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	function automatic logic [15:0] fmt(input logic [11:0] raw, input logic s, input logic [1:0] p);
		logic [11:0] v;
		v = raw ^ {s, 11'h0};
		if (p == `PREC_12_LEFT)
			return {v, 4'h0};
		if (p == `PREC_8_RIGHT)
			return s ? {{8{v[11]}}, v[11:4]} : {8'h0, v[11:4]};
		return s ? {{4{v[11]}}, v} : {4'h0, v};
	endfunction

	task automatic await(ref logic s, input logic v, output int n);
		for (n = 0; n < 3000 && s !== v; n++)
			@(negedge core_clk_i);
	endtask

	// start held a full cycle ahead
	task automatic go(input bit ev);
		@(posedge core_clk_i);
		if (ev)
			event_i <= 1;
		else
			start_write_i <= 1;
		@(posedge core_clk_i);
		event_i <= 0;
		start_write_i <= 0;
		@(negedge core_clk_i);
	endtask

	task automatic flush_flags;
		@(posedge core_clk_i);
		clear_complete_i <= 1;
		clear_compare_i <= 1;
		@(posedge core_clk_i);
		clear_complete_i <= 0;
		clear_compare_i <= 0;
		@(negedge core_clk_i);
	endtask

	task automatic conv(input logic [11:0] lvl, input bit ev, input int h, input logic cf);
		int n;
		int hc;
		level <= lvl;
		go(ev);
		hc = h * (4 << prescale_i);
		await(busy_o, 1, n);
		await(complete_flag_o, 1, n);
		check(16'(n >= hc - 1 && n <= hc + 3), 16'h1);
		check(result_o, fmt(lvl, sign_mode_select_i, precision_i));
		check(16'(compare_flag_o), 16'(cf));
		flush_flags;
	endtask

	task automatic watch(input int want);
		logic prev;
		prev = 0;
		rise_at.delete();
		rise_in.delete();
		for (int n = 0; n < 3000 && rise_at.size() < want; n++)
		begin
			@(negedge core_clk_i);
			if (sample_o === 1'b1 && prev !== 1'b1)
			begin
				rise_at.push_back(n);
				rise_in.push_back(positive_input_o);
			end
			prev = sample_o;
		end
	endtask

	task automatic t_reset;
		@(negedge core_clk_i);
		check(result_o, 16'h0);
		check(16'({busy_o, channel_start_bit_o, complete_flag_o, compare_flag_o}), 16'h0);
		for (int r = 0; r < 8; r++)
		begin
			@(posedge core_clk_i);
			reference_select_i <= 3'(r);
			repeat (2) @(negedge core_clk_i);
			check(16'(reference_o), r > 4 ? 16'h0 : 16'(r));
		end
		$display("test reset and reference done");
	endtask

	task automatic t_format;
		logic [11:0] lv[4] = '{12'h000, 12'hfff, 12'h7ff, 12'h801};
		for (int k = 0; k < 8; k++)
			for (int j = 0; j < 4; j++)
			begin
				@(posedge core_clk_i);
				sign_mode_select_i <= k[0];
				input_mode_i <= k[0] ? `MODE_DIFF : `MODE_SINGLE;
				precision_i <= 2'(k >> 1);
				conv(lv[j], 0, (k >> 1) == 2 ? 11 : 15, 0);
			end
		$display("test formats done");
	endtask

	task automatic t_gain;
		for (int g = 0; g < 9; g++)
		begin
			@(posedge core_clk_i);
			sign_mode_select_i <= 1;
			input_mode_i <= g < 8 ? `MODE_DIFF_GAIN : `MODE_SINGLE;
			gain_select_i <= g < 8 ? 3'(g) : 3'h5;
			conv(12'h9a5, 0, 15 + (g == 7 ? 1 : g % 8), 0);
			check(16'(gain_code_o), g < 8 ? 16'(g) : 16'h0);
		end
		$display("test gain done");
	endtask

	task automatic t_ext;
		int e[3] = '{0, 127, 5};
		int a;
		int b;
		for (int i = 0; i < 3; i++)
		begin
			@(posedge core_clk_i);
			sample_extension_value_i <= 7'(e[i]);
			prescale_i <= 3'(i / 2);
			conv(12'h456, 1, 15 + e[i], 0);
			await(converter_clock_o, 0, a);
			await(converter_clock_o, 1, a);
			await(converter_clock_o, 0, a);
			await(converter_clock_o, 1, b);
			check(16'(a + b), 16'(8 << (i / 2)));
		end
		@(posedge core_clk_i);
		sample_extension_value_i <= 0;
		prescale_i <= 0;
		$display("test sample time done");
	endtask

	task automatic t_scan;
		int n;
		@(posedge core_clk_i);
		input_selector_i <= 4'h3;
		scan_count_i <= 4'h2;
		go(0);
		watch(3);
		check(16'(rise_in.size()), 16'h3);
		foreach (rise_in[i])
			check(16'(rise_in[i]), 16'(3 + i));
		await(busy_o, 0, n);
		repeat (3) @(negedge core_clk_i);
		check(16'(positive_input_o), 16'h3);
		flush_flags;
		@(posedge core_clk_i);
		scan_count_i <= 0;
		continuous_conversion_i <= 1;
		go(1);
		watch(3);
		n = rise_at.size() == 3 ? rise_at[2] - rise_at[1] : 0;
		check(16'(n >= 56 && n <= 60), 16'h1);
		@(posedge core_clk_i);
		continuous_conversion_i <= 0;
		await(busy_o, 0, n);
		flush_flags;
		$display("test scan and continuous done");
	endtask

	task automatic t_cmp;
		@(posedge core_clk_i);
		sign_mode_select_i <= 0;
		input_mode_i <= `MODE_INTERNAL;
		precision_i <= `PREC_12_RIGHT;
		compare_enable_i <= 1;
		compare_above_i <= 1;
		threshold_i <= 12'h400;
		conv(12'h500, 0, 15, 1);
		conv(12'h400, 0, 15, 0);
		@(posedge core_clk_i);
		compare_above_i <= 0;
		conv(12'h3ff, 0, 15, 1);
		conv(12'h400, 0, 15, 0);
		@(posedge core_clk_i);
		compare_enable_i <= 0;
		conv(12'h000, 0, 15, 0);
		$display("test compare done");
	endtask

	initial
	begin
		{enable_i, start_write_i, event_i, sign_mode_select_i} = '0;
		{continuous_conversion_i, compare_enable_i, compare_above_i} = '0;
		{clear_complete_i, clear_compare_i, prescale_i, reference_select_i} = '0;
		{gain_select_i, precision_i, input_selector_i, scan_count_i} = '0;
		{sample_extension_value_i, threshold_i, level} = '0;
		input_mode_i = `MODE_SINGLE;
		rst_b_i = 0;
		repeat (2) @(posedge core_clk_i);
		rst_b_i <= 1;
		enable_i <= 1;
		t_reset;
		t_format;
		t_gain;
		t_ext;
		t_scan;
		t_cmp;
		print_verdict;
	end

	initial
	begin
		repeat (40000) @(posedge core_clk_i);
		miscompares++;
		print_verdict;
	end
endmodule
